// [verilog/ring_validation_pkg.sv]
// constants shared by the ring validation timing block
package ring_validation_pkg;
    // ========================================
    // register map
    localparam logic [7:0]  TIMING_CTRL_ADDR   = 8'h17;
    localparam logic [7:0]  TIMING_CTRL_RESET  = 8'h08;  // timeout code 1, others zero
    localparam int          DELAY_HI_BIT       = 7;
    localparam int          TIMEOUT_MSB        = 6;
    localparam int          TIMEOUT_LSB        = 3;
    localparam int          CONFIRM_MSB        = 2;
    localparam int          CONFIRM_LSB        = 0;

    // ========================================
    // timebase
    localparam int          CLOCK_PERIOD_NS    = 8;
    localparam int          MS_IN_NS           = 1000000;
    localparam int          CYCLES_PER_MS      = MS_IN_NS / CLOCK_PERIOD_NS;
    localparam int          FREQ_STEP_MS       = 2;  // frequency timer step

    // ========================================
    // interval steps and confirmation table, in ms
    localparam logic [10:0] DELAY_STEP_MS      = 11'h100;  // 256 ms
    localparam logic [10:0] TIMEOUT_STEP_MS    = 11'h080;  // 128 ms
    localparam logic [10:0] CONFIRM_MS_0       = 11'h064;  // 100 ms
    localparam logic [10:0] CONFIRM_MS_1       = 11'h096;  // 150 ms
    localparam logic [10:0] CONFIRM_MS_2       = 11'h0C8;  // 200 ms
    localparam logic [10:0] CONFIRM_MS_3       = 11'h100;  // 256 ms
    localparam logic [10:0] CONFIRM_MS_4       = 11'h180;  // 384 ms
    localparam logic [10:0] CONFIRM_MS_5       = 11'h200;  // 512 ms
    localparam logic [10:0] CONFIRM_MS_6       = 11'h280;  // 640 ms
    localparam logic [10:0] CONFIRM_MS_7       = 11'h400;  // 1024 ms

    // ========================================
    // ring qualification states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CONFIRM = 2'b01,
        ST_DELAY   = 2'b10,
        ST_VALID   = 2'b11
    } ring_state_t;
endpackage

// [verilog/ring_validation_timing.sv]
// ring validation timing: control register, ms timebase and ring qualifier
`timescale 1ns/1ps
module ring_validation_timing #(
    parameter int CYCLES_PER_MS = ring_validation_pkg::CYCLES_PER_MS
) (
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic [1:0] i_delay_code_lo,
    input  wire logic [5:0] i_ring_max_freq_limit,
    input  wire logic [5:0] i_ring_min_freq_limit,
    input  wire logic       i_ring_validation_enable,
    input  wire logic       i_ring_event,
    output logic            o_ring_active,
    output logic            o_ring_valid
);
    // ========================================
    // elaboration check
    if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > 131071)
    begin : g_bad_rate
        $error("cycles per ms out of range");
    end

    // ========================================
    // control register and read port
    logic [7:0] ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;

    // write on address match, read registered
    always_comb
    begin
        ctrl_nxt  = ctrl_r;
        rdata_nxt = 8'h00;
        if (i_reg_wr && i_reg_addr == ring_validation_pkg::TIMING_CTRL_ADDR)
            ctrl_nxt = i_reg_wdata;
        if (i_reg_addr == ring_validation_pkg::TIMING_CTRL_ADDR)
            rdata_nxt = ctrl_r;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            ctrl_r  <= ring_validation_pkg::TIMING_CTRL_RESET;
            rdata_r <= 8'h00;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;

    // ========================================
    // field decode
    logic [2:0]  valid_ring_delay_code;
    logic [3:0]  ring_end_timeout;
    logic [2:0]  ring_confirm_time;
    logic [10:0] delay_ms, timeout_ms, confirm_ms;

    assign valid_ring_delay_code = {ctrl_r[ring_validation_pkg::DELAY_HI_BIT], i_delay_code_lo};
    assign ring_end_timeout  = ctrl_r[ring_validation_pkg::TIMEOUT_MSB:ring_validation_pkg::TIMEOUT_LSB];
    assign ring_confirm_time = ctrl_r[ring_validation_pkg::CONFIRM_MSB:ring_validation_pkg::CONFIRM_LSB];
    assign delay_ms   = 11'(11'(valid_ring_delay_code) * ring_validation_pkg::DELAY_STEP_MS);
    assign timeout_ms = 11'(11'(ring_end_timeout) * ring_validation_pkg::TIMEOUT_STEP_MS);

    // confirmation time table
    always_comb
    begin
        case (ring_confirm_time)
            3'h0:    confirm_ms = ring_validation_pkg::CONFIRM_MS_0;
            3'h1:    confirm_ms = ring_validation_pkg::CONFIRM_MS_1;
            3'h2:    confirm_ms = ring_validation_pkg::CONFIRM_MS_2;
            3'h3:    confirm_ms = ring_validation_pkg::CONFIRM_MS_3;
            3'h4:    confirm_ms = ring_validation_pkg::CONFIRM_MS_4;
            3'h5:    confirm_ms = ring_validation_pkg::CONFIRM_MS_5;
            3'h6:    confirm_ms = ring_validation_pkg::CONFIRM_MS_6;
            default: confirm_ms = ring_validation_pkg::CONFIRM_MS_7;
        endcase
    end

    // ========================================
    // free-running ms tick and 2 ms frequency tick
    logic [16:0] div_r, div_nxt;
    logic        half_r, half_nxt;
    logic        ms_tick, freq_tick;

    assign ms_tick   = (div_r == 17'(CYCLES_PER_MS - 1));
    assign freq_tick = ms_tick && half_r;

    always_comb
    begin
        div_nxt  = ms_tick ? 17'h00000 : 17'(div_r + 17'h00001);
        half_nxt = ms_tick ? !half_r : half_r;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            div_r  <= 17'h00000;
            half_r <= 1'b0;
        end
        else
        begin
            div_r  <= div_nxt;
            half_r <= half_nxt;
        end
    end

    // ========================================
    // frequency window timer
    ring_validation_pkg::ring_state_t state_r, state_nxt;
    logic [5:0] ftimer_r, ftimer_nxt;
    logic       freq_bad;

    // too slow if expired, too fast if too much left
    assign freq_bad = i_ring_validation_enable && i_ring_event && state_r != ring_validation_pkg::ST_IDLE
                      && (ftimer_r == 6'h00 || ftimer_r > i_ring_max_freq_limit);

    always_comb
    begin
        ftimer_nxt = ftimer_r;
        if (i_ring_event)
            ftimer_nxt = i_ring_min_freq_limit;
        else if (freq_tick && ftimer_r != 6'h00)
            ftimer_nxt = 6'(ftimer_r - 6'h01);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
            ftimer_r <= 6'h00;
        else
            ftimer_r <= ftimer_nxt;
    end

    // ========================================
    // ring qualifier state machine
    logic [10:0] cnt_r, cnt_nxt, since_r, since_nxt;
    logic        valid_r, valid_nxt;
    logic        timeout_hit;
    logic [10:0] cnt_inc, since_inc;

    assign cnt_inc     = 11'(cnt_r + 11'h001);
    assign since_inc   = 11'(since_r + 11'h001);
    assign timeout_hit = state_r != ring_validation_pkg::ST_IDLE && ms_tick && !i_ring_event
                         && since_inc >= timeout_ms;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        since_nxt = i_ring_event ? 11'h000 : (ms_tick && since_r != 11'h7FF ? since_inc : since_r);
        case (state_r)
            ring_validation_pkg::ST_IDLE:
            begin
                cnt_nxt = 11'h000;
                if (i_ring_event)
                    state_nxt = i_ring_validation_enable ? ring_validation_pkg::ST_CONFIRM
                                                         : ring_validation_pkg::ST_VALID;
            end
            ring_validation_pkg::ST_CONFIRM:
            begin
                if (timeout_hit)
                    state_nxt = ring_validation_pkg::ST_IDLE;
                else if (freq_bad)
                    cnt_nxt = 11'h000;
                else if (ms_tick)
                begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc >= confirm_ms)
                    begin
                        state_nxt = ring_validation_pkg::ST_DELAY;
                        cnt_nxt   = 11'h000;
                    end
                end
            end
            ring_validation_pkg::ST_DELAY:
            begin
                if (timeout_hit)
                    state_nxt = ring_validation_pkg::ST_IDLE;
                else if (freq_bad)
                begin
                    state_nxt = ring_validation_pkg::ST_CONFIRM;
                    cnt_nxt   = 11'h000;
                end
                else if (delay_ms == 11'h000)
                    state_nxt = ring_validation_pkg::ST_VALID;
                else if (ms_tick)
                begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc >= delay_ms)
                        state_nxt = ring_validation_pkg::ST_VALID;
                end
            end
            default:
            begin
                if (timeout_hit)
                    state_nxt = ring_validation_pkg::ST_IDLE;
            end
        endcase
        valid_nxt = (state_nxt == ring_validation_pkg::ST_VALID);
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            state_r <= ring_validation_pkg::ST_IDLE;
            cnt_r   <= 11'h000;
            since_r <= 11'h000;
            valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            since_r <= since_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign o_ring_valid  = valid_r;
    assign o_ring_active = (state_r != ring_validation_pkg::ST_IDLE);

    // ========================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    sequence s_ring_start;
        state_r == ring_validation_pkg::ST_IDLE && i_ring_event;
    endsequence

    sequence s_confirm_done;
        state_r == ring_validation_pkg::ST_CONFIRM && ms_tick && !timeout_hit && !freq_bad
        && cnt_inc >= confirm_ms;
    endsequence

    a_delay_code_form: assert property (delay_ms[10] == ctrl_r[ring_validation_pkg::DELAY_HI_BIT]
        && delay_ms[9:8] == i_delay_code_lo && delay_ms[7:0] == 8'h00) else $error("delay code misformed");
    a_delay_zero_pass: assert property (s_confirm_done ##1 (delay_ms == 11'h000 && !timeout_hit && !freq_bad)
        |=> o_ring_valid) else $error("zero delay not immediate");
    a_delay_holds: assert property (state_r == ring_validation_pkg::ST_DELAY && delay_ms != 11'h000
        && !ms_tick |=> !o_ring_valid) else $error("valid raised between delay ticks");
    a_timeout_ends: assert property (timeout_hit |=> !o_ring_active && !o_ring_valid)
        else $error("ring not ended at timeout");
    a_confirm_gate: assert property (s_confirm_done |=> state_r == ring_validation_pkg::ST_DELAY
        && cnt_r == 11'h000) else $error("confirmation not reached");
    a_valid_cause: assert property ($rose(o_ring_valid) && i_ring_validation_enable
        |-> $past(state_r) == ring_validation_pkg::ST_DELAY) else $error("valid without delay stage");
    a_confirm_table: assert property (ring_confirm_time == 3'h4 |-> confirm_ms == 11'h180)
        else $error("confirm table wrong");
    a_slow_reject: assert property (state_r == ring_validation_pkg::ST_CONFIRM && freq_bad
        && !timeout_hit |=> cnt_r == 11'h000 && state_r == ring_validation_pkg::ST_CONFIRM)
        else $error("bad frequency not rejected");
    a_timer_reload: assert property (i_ring_event |=> ftimer_r == $past(i_ring_min_freq_limit))
        else $error("frequency timer not reloaded");
    a_fast_reject: assert property ((state_r == ring_validation_pkg::ST_CONFIRM
        || state_r == ring_validation_pkg::ST_DELAY) && i_ring_event
        && i_ring_validation_enable && ftimer_r > i_ring_max_freq_limit && !timeout_hit
        |=> state_r == ring_validation_pkg::ST_CONFIRM && cnt_r == 11'h000)
        else $error("fast ring not rejected");
    a_bypass_valid: assert property (s_ring_start ##0 !i_ring_validation_enable
        |=> o_ring_valid ##0 o_ring_active) else $error("bypass not immediate");
    a_start_restart: assert property (s_ring_start |=> cnt_r == 11'h000 && since_r == 11'h000)
        else $error("interval counters not restarted");
endmodule

// [tb/ring_line_model.sv]
// line-side ring source: one-cycle threshold crossing pulses at a set spacing
`timescale 1ns/1ps
module ring_line_model (
    input  wire logic        i_clock,
    input  wire logic        i_run,
    input  wire logic [15:0] i_period,
    output logic             o_ring_event
);
    logic [15:0] gap_r;
    logic        run_q;
    logic [15:0] period_q;

    // ========================================
    // pulse train
    // pulse on the first edge of a run, then once every i_period cycles
    initial
    begin
        o_ring_event = 1'b0;
        gap_r        = 16'h0000;
    end
    // controls taken at the edge, before the bench moves them, then driven 1 ns later
    always @(posedge i_clock)
    begin
        run_q    = i_run;
        period_q = i_period;
        #1;
        o_ring_event = run_q && (gap_r == 16'h0000);
        if (!run_q || gap_r == period_q - 16'h0001)
            gap_r = 16'h0000;
        else
            gap_r = gap_r + 16'h0001;
    end
endmodule

// [tb/tb.sv]
// self-checking bench for the ring validation timing block
`timescale 1ns/1ps
module tb;
    localparam int C = 10;  // clock cycles per ms tick in simulation
    logic        i_clock;
    logic        i_nrst;
    logic [7:0]  i_reg_addr;
    logic        i_reg_wr;
    logic [7:0]  i_reg_wdata;
    logic [7:0]  o_reg_rdata;
    logic [1:0]  i_delay_code_lo;
    logic [5:0]  i_ring_max_freq_limit;
    logic [5:0]  i_ring_min_freq_limit;
    logic        i_ring_validation_enable;
    logic        ring_event;
    logic        o_ring_active;
    logic        o_ring_valid;
    logic        run;
    logic [15:0] period;
    int          err_count;
    int          samples_checked;
    int          cycles;
    int          n;
    logic [7:0]  d;
    int          conf_ms [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};

    // ========================================
    // design and line-side model
    ring_validation_timing #(.CYCLES_PER_MS(C)) u_dut (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_delay_code_lo(i_delay_code_lo), .i_ring_max_freq_limit(i_ring_max_freq_limit),
        .i_ring_min_freq_limit(i_ring_min_freq_limit), .i_ring_validation_enable(i_ring_validation_enable),
        .i_ring_event(ring_event), .o_ring_active(o_ring_active), .o_ring_valid(o_ring_valid));
    ring_line_model u_line (.i_clock(i_clock), .i_run(run), .i_period(period), .o_ring_event(ring_event));

    // ========================================
    // clock and hang guard
    initial i_clock = 1'b0;
    always #4 i_clock = ~i_clock;
    always @(posedge i_clock)
    begin
        cycles = cycles + 1;
        if (cycles == 100000)
        begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    // ========================================
    // access and compare tasks
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        #1 i_reg_addr = a;
        i_reg_wr = 1'b1;
        i_reg_wdata = v;
        @(posedge i_clock);
        #1 i_reg_wr = 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_clock);
        #1 i_reg_addr = a;
        @(posedge i_clock);
        #1 v = o_reg_rdata;
    endtask
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_range(input int got, input int lo, input int hi);
        samples_checked = samples_checked + 1;
        if (got < lo || got > hi)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // counts cycles until the valid flag reaches lvl, giving up at lim
    task automatic wait_valid(input logic lvl, input int lim, output int k);
        k = 0;
        while (o_ring_valid !== lvl && k < lim)
        begin
            @(posedge i_clock);
            #1 k = k + 1;
        end
    endtask
    // one enabled ring at 25 ms spacing; valid expected after exp_ms
    task automatic ring_case(input logic hi, input logic [1:0] lo, input logic [2:0] cc, input int exp_ms);
        reg_write(8'h17, {hi, 4'h1, cc});
        i_delay_code_lo = lo;
        period = 16'd250;
        run = 1'b1;
        wait_valid(1'b1, (exp_ms + 4) * C, n);
        check_range(n, (exp_ms - 2) * C, (exp_ms + 2) * C);
        run = 1'b0;
        wait_valid(1'b0, 140 * C, n);
    endtask
    task automatic complete_run();
        $display("checks %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================
    // main sequence
    initial
    begin
        {i_reg_addr, i_reg_wr, i_reg_wdata, i_delay_code_lo, run} = '0;
        i_ring_max_freq_limit = 6'h05;
        i_ring_min_freq_limit = 6'h0F;
        i_ring_validation_enable = 1'b0;
        period = 16'd250;
        err_count = 0;
        samples_checked = 0;
        cycles = 0;
        i_nrst = 1'b0;
        repeat (20) @(posedge i_clock);
        #1 i_nrst = 1'b1;
        reg_read(8'h17, d);
        check_val(d, ring_validation_pkg::TIMING_CTRL_RESET);
        reg_write(8'h16, 8'h55);
        reg_read(8'h16, d);
        check_val(d, 8'h00);
        reg_read(8'h17, d);
        check_val(d, ring_validation_pkg::TIMING_CTRL_RESET);
        reg_write(8'h17, 8'hFF);
        reg_read(8'h17, d);
        check_val(d, 8'hFF);
        // bypass mode: single crossing, ring ends after the timeout
        for (int to = 1; to <= 3; to = to + 2)
        begin
            reg_write(8'h17, {1'b0, to[3:0], 3'h7});
            run = 1'b1;
            @(posedge i_clock);
            #1 run = 1'b0;
            wait_valid(1'b1, 4, n);
            check_range(n, 0, 2);
            wait_valid(1'b0, (to * 128 + 4) * C, n);
            check_range(n, (to * 128 - 1) * C, (to * 128 + 1) * C + 2);
            check_val({7'h00, o_ring_active}, 8'h00);
        end
        // validation on: every confirmation code, then delay codes
        i_ring_validation_enable = 1'b1;
        for (int cc = 0; cc < 8; cc++)
            ring_case(1'b0, 2'h0, cc[2:0], conf_ms[cc]);
        ring_case(1'b0, 2'h2, 3'h0, 612);
        ring_case(1'b1, 2'h1, 3'h0, 1380);
        // too slow (40 ms) then too fast (5 ms): never valid
        for (int p = 0; p < 2; p++)
        begin
            period = (p == 0) ? 16'd400 : 16'd50;
            run = 1'b1;
            wait_valid(1'b1, 300 * C, n);
            check_range(n, 300 * C, 300 * C);
            check_val({7'h00, o_ring_active}, 8'h01);
            run = 1'b0;
            wait_valid(1'b0, 140 * C, n);
            repeat (140 * C) @(posedge i_clock);
        end
        complete_run();
    end
endmodule
